// ---- src/smsr_defs.vh ----
// register map, field positions, reset values and divider counts
`ifndef SMSR_DEFS_VH
`define SMSR_DEFS_VH

// ======================================================================
// register offsets
`define SMSR_ADDR_DATA 8'h21
`define SMSR_ADDR_CTRL 8'h22
`define SMSR_ADDR_STAT 8'h23

// ======================================================================
// serial_control fields
`define SMSR_CR_IRQ_EN 7
`define SMSR_CR_PIN_EN 6
`define SMSR_CR_DIV_HI 5
`define SMSR_CR_MASTER 4
`define SMSR_CR_CLK_POL 3
`define SMSR_CR_CLK_PHA 2
`define SMSR_CR_DIV_LO1 1
`define SMSR_CR_DIV_LO0 0

// ======================================================================
// serial_control_status fields
`define SMSR_SR_DONE 7
`define SMSR_SR_COLL 6
`define SMSR_SR_OVERRUN 5
`define SMSR_SR_FAULT 4
`define SMSR_SR_RSVD 3
`define SMSR_SR_OUT_DIS 2
`define SMSR_SR_SOFT_SEL 1
`define SMSR_SR_INT_SEL 0

// ======================================================================
// reset values
`define SMSR_CTRL_RST 8'h00
`define SMSR_STAT_RST 8'h00
`define SMSR_DATA_RST 8'h00

// ======================================================================
// divider selections and half periods of sck in clk cycles
`define SMSR_DIV_4 3'b100
`define SMSR_DIV_8 3'b000
`define SMSR_DIV_16 3'b001
`define SMSR_DIV_32 3'b110
`define SMSR_DIV_64 3'b010
`define SMSR_DIV_128 3'b011
`define SMSR_HALF_4 7'd2
`define SMSR_HALF_8 7'd4
`define SMSR_HALF_16 7'd8
`define SMSR_HALF_32 7'd16
`define SMSR_HALF_64 7'd32
`define SMSR_HALF_128 7'd64

// ======================================================================
// sixteen sck edges per byte, index of the last one
`define SMSR_LAST_EDGE 4'hf

`endif

// ---- src/smsr_sync.v ----
// two flip-flop synchronisers for the serial pins
module smsr_sync #(
   parameter WIDTH = 4
) (
   input wire clk,
   input wire rstn,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);

   // ======================================================================
   // one pair of flops per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg sync_q;
         always @(posedge clk) begin
            if (!rstn) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate

endmodule // smsr_sync

// ---- src/smsr_core.v ----
// byte-wide serial peripheral, master or slave, with its registers
// Notes on behaviour
// RQ1: irq raised while enabled and done, fault or overrun flag set.
// RQ2: pin enable cleared by reset and by fault; clear frees pins.
// RQ3: master bit drives sck and swaps data pins; cleared on fault.
// RQ4: polarity bit sets sck idle level in both modes; core uses it only for sck_o, driven in master mode.
// RQ5: phase 0 captures on first sck edge, phase 1 on second.
// RQ6: master sck divider codes give clk over 4 up to 128.
// RQ7: divider bits ignored in slave mode.
// RQ8: done flag set per byte; cleared by status read then data access.
// RQ9: data writes ignored while done set until status read.
// RQ10: data write during a transfer sets the collision flag.
// RQ11: overrun set when byte ends with done still set; status read clears.
// RQ12: fault set on select low as master; status read then ctrl write clears.
// RQ13: software writes zero to the unused status bit.
// RQ14: output disable removes the data output drive.
// RQ15: soft select ignores select pin and uses internal select bit.
// RQ16: internal select bit 0 selects, 1 deselects.
// RQ17: master data write starts one byte out and one in.
// RQ18: received byte copied to buffer at completion; reads see buffer.
// RQ19: data write loads the shift register directly.
// RQ20: status and upper control bits reset to zero.
// RQ21: software clears pin enable before changing polarity.
// RQ22: both ends use the same polarity and phase.
// RQ23: while fault set, pin enable and master cannot be set.
// RQ24: after overrun the buffer keeps the first byte.
// RQ25: colliding write has no effect on the running transfer.
// RQ26: eight bits per byte, msb first, both data lines at once.
//
// The address-and-strobe port was decided locally.
`include "smsr_defs.vh"

module smsr_core (
   input wire clk,
   input wire rstn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   output wire irq,
   input wire sck_i,
   output wire sck_o,
   output wire sck_oe_n,
   input wire mosi_i,
   output wire mosi_o,
   output wire mosi_oe_n,
   input wire miso_i,
   output wire miso_o,
   output wire miso_oe_n,
   input wire ss_n_i
);

   // ======================================================================
   // state
   reg [7:0] ctrl_q;
   reg [7:0] ctrl_d;
   reg done_q;
   reg coll_q;
   reg overrun_q;
   reg fault_q;
   reg out_dis_q;
   reg soft_sel_q;
   reg int_sel_q;
   reg seq_arm_q;
   reg fault_arm_q;
   reg [7:0] rxbuf_q;
   reg [7:0] sh_q;
   reg out_q;
   reg sck_q;
   reg busy_q;
   reg [3:0] cnt_q;
   reg [6:0] div_q;
   reg sck_prev_q;
   reg [7:0] rdata_q;
   reg [6:0] half;

   // ======================================================================
   // pin synchronisers
   wire [3:0] pins_s;
   smsr_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({ss_n_i, sck_i, mosi_i, miso_i}),
      .q(pins_s)
   );
   wire ss_n_s = pins_s[3];
   wire sck_s = pins_s[2];
   wire mosi_s = pins_s[1];
   wire miso_s = pins_s[0];

   // ======================================================================
   // control fields
   wire irq_en = ctrl_q[`SMSR_CR_IRQ_EN];
   wire pin_en = ctrl_q[`SMSR_CR_PIN_EN];
   wire master = ctrl_q[`SMSR_CR_MASTER];
   wire clk_pol = ctrl_q[`SMSR_CR_CLK_POL];
   wire clk_pha = ctrl_q[`SMSR_CR_CLK_PHA];
   wire [2:0] div_sel = {ctrl_q[`SMSR_CR_DIV_HI],
      ctrl_q[`SMSR_CR_DIV_LO1], ctrl_q[`SMSR_CR_DIV_LO0]};

   // ======================================================================
   // bus decode
   wire wr_data = reg_wr & (reg_addr == `SMSR_ADDR_DATA);
   wire wr_ctrl = reg_wr & (reg_addr == `SMSR_ADDR_CTRL);
   wire wr_stat = reg_wr & (reg_addr == `SMSR_ADDR_STAT);
   wire rd_data = reg_rd & (reg_addr == `SMSR_ADDR_DATA);
   wire rd_stat = reg_rd & (reg_addr == `SMSR_ADDR_STAT);

   // ======================================================================
   // slave select
   // RQ15: soft select source
   // RQ16: low level selects
   wire sel_n = soft_sel_q ? int_sel_q : ss_n_s;
   // RQ12: fault detect
   wire fault_ev = master & ~sel_n;

   // ======================================================================
   // master clock divider
   // RQ6: divider decode
   always @* begin
      case (div_sel)
         `SMSR_DIV_4: half = `SMSR_HALF_4;
         `SMSR_DIV_8: half = `SMSR_HALF_8;
         `SMSR_DIV_16: half = `SMSR_HALF_16;
         `SMSR_DIV_32: half = `SMSR_HALF_32;
         `SMSR_DIV_64: half = `SMSR_HALF_64;
         `SMSR_DIV_128: half = `SMSR_HALF_128;
         default: half = `SMSR_HALF_128;
      endcase
   end

   // ======================================================================
   // edge and transfer events
   wire m_edge = busy_q & (div_q == (half - 7'd1));
   // RQ7: slave uses external sck
   wire s_active = pin_en & ~master & ~sel_n;
   wire s_edge = s_active & (sck_s != sck_prev_q);
   wire shift_edge = master ? m_edge : s_edge;
   // RQ5: capture edge parity
   wire capture = shift_edge & (cnt_q[0] == clk_pha);
   // RQ3: data pins swap with mode
   wire din = master ? miso_s : mosi_s;
   // RQ26: msb first shift
   wire [7:0] sh_cap = {sh_q[6:0], din};
   wire last = shift_edge & (cnt_q == `SMSR_LAST_EDGE);
   wire [7:0] new_byte = capture ? sh_cap : sh_q;
   wire xfer_busy = master ? busy_q : (cnt_q != 4'h0);

   // RQ9: writes blocked while done
   wire blocked = done_q & ~seq_arm_q;
   // RQ10: collision detect
   wire coll_ev = wr_data & xfer_busy;
   // RQ25: colliding write dropped
   wire load = wr_data & ~xfer_busy & ~blocked;
   // RQ17: write starts master byte
   wire start = load & master & pin_en & ~fault_q;
   wire seq_clr = seq_arm_q & (wr_data | rd_data);

   // ======================================================================
   // control register next value
   always @* begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = reg_wdata;
         // RQ23: refuse setting while fault
         if (fault_q & ~fault_arm_q) begin
            ctrl_d[`SMSR_CR_PIN_EN] = 1'b0;
            ctrl_d[`SMSR_CR_MASTER] = 1'b0;
         end
      end
      // RQ2: fault drops pin enable
      // RQ3: fault drops master
      if (fault_ev) begin
         ctrl_d[`SMSR_CR_PIN_EN] = 1'b0;
         ctrl_d[`SMSR_CR_MASTER] = 1'b0;
      end
   end

   // ======================================================================
   // registers written by software
   always @(posedge clk) begin
      if (!rstn) begin
         // RQ20: reset values
         ctrl_q <= `SMSR_CTRL_RST;
         out_dis_q <= 1'b0;
         soft_sel_q <= 1'b0;
         int_sel_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_stat) begin
            out_dis_q <= reg_wdata[`SMSR_SR_OUT_DIS];
            soft_sel_q <= reg_wdata[`SMSR_SR_SOFT_SEL];
            int_sel_q <= reg_wdata[`SMSR_SR_INT_SEL];
         end
      end
   end

   // ======================================================================
   // status flags, set wins over clear
   always @(posedge clk) begin
      if (!rstn) begin
         done_q <= 1'b0;
         coll_q <= 1'b0;
         overrun_q <= 1'b0;
         fault_q <= 1'b0;
         seq_arm_q <= 1'b0;
         fault_arm_q <= 1'b0;
      end else begin
         // RQ8: done set and cleared
         if (last)
            done_q <= 1'b1;
         else if (seq_clr)
            done_q <= 1'b0;
         // RQ10: collision flag
         if (coll_ev)
            coll_q <= 1'b1;
         else if (seq_clr)
            coll_q <= 1'b0;
         // RQ11: overrun flag
         if (last & done_q)
            overrun_q <= 1'b1;
         else if (rd_stat)
            overrun_q <= 1'b0;
         // RQ12: fault flag sequence
         if (fault_ev)
            fault_q <= 1'b1;
         else if (wr_ctrl & fault_arm_q)
            fault_q <= 1'b0;
         // RQ8: status read arms
         if (rd_stat)
            seq_arm_q <= 1'b1;
         else if (wr_data | rd_data)
            seq_arm_q <= 1'b0;
         // RQ12: arm while fault set
         if (rd_stat & fault_q)
            fault_arm_q <= 1'b1;
         else if (wr_ctrl)
            fault_arm_q <= 1'b0;
      end
   end

   // ======================================================================
   // receive buffer
   always @(posedge clk) begin
      if (!rstn) begin
         rxbuf_q <= `SMSR_DATA_RST;
      end else if (last & ~done_q) begin
         // RQ18: copy at completion
         // RQ24: first byte kept on overrun
         rxbuf_q <= new_byte;
      end
   end

   // ======================================================================
   // transfer sequencer
   always @(posedge clk) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         div_q <= 7'h00;
         sck_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
         if (fault_ev | ~pin_en) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            div_q <= 7'h00;
            sck_q <= 1'b0;
         end else if (start) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
            div_q <= 7'h00;
            sck_q <= 1'b0;
         end else if (~master & sel_n) begin
            cnt_q <= 4'h0;
         end else if (shift_edge) begin
            // RQ26: sixteen edges per byte
            cnt_q <= cnt_q + 4'h1;
            sck_q <= ~sck_q;
            div_q <= 7'h00;
            if (last)
               busy_q <= 1'b0;
         end else if (busy_q) begin
            div_q <= div_q + 7'h01;
         end
      end
   end

   // ======================================================================
   // shift register
   always @(posedge clk) begin
      if (!rstn) begin
         sh_q <= `SMSR_DATA_RST;
         out_q <= 1'b0;
      end else if (load) begin
         // RQ19: direct load
         sh_q <= reg_wdata;
         out_q <= reg_wdata[7];
      end else if (capture) begin
         sh_q <= sh_cap;
      end else if (shift_edge) begin
         out_q <= sh_q[7];
      end
   end

   // ======================================================================
   // register read port
   always @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            // RQ18: reads see buffer
            `SMSR_ADDR_DATA: rdata_q <= rxbuf_q;
            `SMSR_ADDR_CTRL: rdata_q <= ctrl_q;
            `SMSR_ADDR_STAT: rdata_q <= {done_q, coll_q, overrun_q,
               fault_q, 1'b0, out_dis_q, soft_sel_q, int_sel_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // ======================================================================
   // interrupt and pins
   // RQ1: interrupt request
   assign irq = irq_en & (done_q | fault_q | overrun_q);
   // RQ4: sck idle level
   assign sck_o = sck_q ^ clk_pol;
   // RQ2: pins only with enable
   assign sck_oe_n = ~(pin_en & master);
   assign mosi_o = out_q;
   assign miso_o = out_q;
   // RQ14: output disable
   assign mosi_oe_n = ~(pin_en & master & ~out_dis_q);
   assign miso_oe_n = ~(pin_en & ~master & ~sel_n & ~out_dis_q);

endmodule // smsr_core

// ---- tb/smsr_core_properties.sv ----
// port checks for the serial peripheral core
module smsr_chk (
   input wire clk,
   input wire rstn,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire irq,
   input wire sck_o,
   input wire sck_oe_n,
   input wire mosi_o,
   input wire mosi_oe_n,
   input wire miso_o,
   input wire miso_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ======================================================
   // assertions
   a_reset_quiet: assert property (disable iff (1'b0)
      !rstn |=> reg_rdata == 8'h00 && !irq && sck_oe_n && mosi_oe_n)
      else $error("outputs not quiet after reset");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (
      $past(reg_rd) && ($past(reg_addr) < 8'h21 || $past(reg_addr) > 8'h23)
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_sck_miso_excl: assert property (
      !sck_oe_n |-> miso_oe_n) else $error("master drives miso");
   a_mosi_gate: assert property (
      !mosi_oe_n |-> !sck_oe_n) else $error("mosi driven as slave");
   a_mosi_moves: assert property (
      !sck_oe_n && $changed(mosi_o) |-> $changed(sck_o) || $past(reg_wr))
      else $error("mosi changed off a shift edge");
   a_irq_fall_cause: assert property (
      $fell(irq) |-> $past(reg_rd) || $past(reg_wr))
      else $error("irq fell without access");
   a_sck_half_min: assert property (
      !sck_oe_n && $changed(sck_o) && !reg_wr |=> $stable(sck_o) || sck_oe_n)
      else $error("sck half period too short");
endmodule // smsr_chk

bind smsr_core smsr_chk chk_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
   .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_o(mosi_o),
   .mosi_oe_n(mosi_oe_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n));

// ---- tb/smsr_slave.sv ----
// external slave model for master mode transfers
module smsr_slave (
   input wire sck,
   input wire mosi,
   input wire sel_n,
   input wire clock_polarity_bit,
   input wire clock_phase_bit,
   input wire slow,
   input wire load,
   input wire [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   int n;
   // each toggle of load reloads the byte to send
   always @(load) begin
      sh = tx;
      n = 0;
   end
   always @(sck) begin
      if (!sel_n && sck == !(clock_polarity_bit ^ clock_phase_bit)) begin
         rx = {rx[6:0], mosi};
         n++;
      end else if (!sel_n && n > 0) begin
         sh = {sh[6:0], 1'b0};
      end
   end
   // released line shows the inverse bit
   always @(sh or sel_n) miso <= #(slow ? 4 : 1) sel_n ^ sh[7];
endmodule // smsr_slave

// ---- tb/smsr_core_tb.sv ----
// self-checking bench for the serial peripheral core
module smsr_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, reg_wr, reg_rd, ss_n, m_sck, m_mosi, ld, clock_polarity_bit, clock_phase_bit;
   logic p_sel_n, slow;
   logic [7:0] reg_addr, reg_wdata, tx, ptx, got;
   logic [2:0] dc [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
   wire [7:0] reg_rdata, rx;
   wire irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, p_miso;
   wire sck = sck_oe_n ? m_sck : sck_o;
   wire mosi = mosi_oe_n ? m_mosi : mosi_o;
   wire miso = miso_oe_n ? p_miso : miso_o;
   int n_errors, cmp_count, seed, cyc, edges, gap, t0, i;
   logic [7:0] q[$];
   smsr_core dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .sck_i(sck), .sck_o(sck_o),
      .sck_oe_n(sck_oe_n), .mosi_i(mosi), .mosi_o(mosi_o),
      .mosi_oe_n(mosi_oe_n), .miso_i(miso), .miso_o(miso_o),
      .miso_oe_n(miso_oe_n), .ss_n_i(ss_n));
   smsr_slave part_u (.sck(sck), .mosi(mosi), .sel_n(p_sel_n), .clock_polarity_bit(clock_polarity_bit),
      .clock_phase_bit(clock_phase_bit), .slow(slow), .load(ld), .tx(ptx), .miso(p_miso), .rx(rx));
   // ======================================================
   // tasks
   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
      @(posedge clk);
   endtask
   task automatic mxfer(logic [7:0] b, output logic [7:0] r);
      for (int k = 7; k >= 0; k--) begin
         m_mosi <= b[k];
         repeat (6) @(posedge clk);
         r[k] = miso;
         m_sck <= 1'b1;
         repeat (6) @(posedge clk);
         m_sck <= 1'b0;
      end
   endtask
   always @(sck_o) if (!sck_oe_n) begin
      edges++;
      gap = cyc - t0;
      t0 = cyc;
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      cyc = 0;
      forever begin
         @(posedge clk);
         cyc++;
         if (cyc > 20000) begin
            n_errors++;
            stop_test();
         end
      end
   end
   // ======================================================
   // main sequence
   initial begin
      {n_errors, cmp_count, edges, gap, t0} = '0;
      seed = 32'h5b0a;
      {rstn, reg_wr, reg_rd, m_sck, m_mosi, ld, clock_polarity_bit, clock_phase_bit, slow} = '0;
      {ss_n, p_sel_n} = 2'b11;
      {reg_addr, reg_wdata, ptx} = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd(8'h22, 8'h00);
      rd(8'h23, 8'h00);
      wr(8'h24, 8'h5a);
      rd(8'h24, 8'h00);
      p_sel_n = 1'b0;
      for (i = 0; i < 6; i++) begin
         {clock_polarity_bit, clock_phase_bit} = i[1:0];
         slow = i[0];
         tx = 8'($random(seed));
         ptx = (i == 0) ? 8'hff : 8'($random(seed));
         wr(8'h22, {2'b10, dc[i][2], 1'b1, clock_polarity_bit, clock_phase_bit, dc[i][1:0]});
         wr(8'h22, {2'b11, dc[i][2], 1'b1, clock_polarity_bit, clock_phase_bit, dc[i][1:0]});
         ld = ~ld;
         chk("sck_idle", {7'h0, clock_polarity_bit}, {7'h0, sck_o});
         edges = 0;
         wr(8'h21, tx);
         wr(8'h21, ~tx);
         for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
         chk("irq", 8'h01, {7'h0, irq});
         chk("half", 8'(2 << i), 8'(gap));
         chk("edges", 8'd16, 8'(edges));
         rd(8'h23, 8'hc0);
         rd(8'h21, ptx);
         chk("rx", tx, rx);
         rd(8'h23, 8'h00);
      end
      p_sel_n = 1'b1;
      wr(8'h22, 8'h40);
      ss_n <= 1'b0;
      wr(8'h21, 8'h3c);
      mxfer(8'h96, got);
      chk("miso", 8'h3c, got);
      chk("miso_oe_n", 8'h00, {7'h0, miso_oe_n});
      q.push_back(8'h96);
      mxfer(8'h69, got);
      repeat (8) @(posedge clk);
      chk("irq_off", 8'h00, {7'h0, irq});
      rd(8'h23, 8'ha0);
      rd(8'h21, q.pop_front());
      rd(8'h23, 8'h00);
      wr(8'h23, 8'h07);
      wr(8'h22, 8'hd0);
      chk("mosi_oe_n", 8'h01, {7'h0, mosi_oe_n});
      rd(8'h23, 8'h07);
      wr(8'h23, 8'h02);
      repeat (4) @(posedge clk);
      chk("irq", 8'h01, {7'h0, irq});
      chk("sck_oe_n", 8'h01, {7'h0, sck_oe_n});
      rd(8'h22, 8'h80);
      wr(8'h22, 8'hd0);
      rd(8'h22, 8'h80);
      wr(8'h23, 8'h03);
      ss_n <= 1'b1;
      rd(8'h23, 8'h13);
      wr(8'h22, 8'hd0);
      rd(8'h23, 8'h03);
      rd(8'h22, 8'hd0);
      stop_test();
   end
endmodule // smsr_core_tb
